// ### design/tpr_tx_stamp.v
`timescale 1ns/1ps
`include "tpr_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Op code 00 takes no timestamp and passes the frame unchanged; 11 never used.
// - Op code 01 captures a timestamp and writes it into the frame.
// - Op code 10 captures a timestamp, returns it, frame left unaltered.
// - The tag input is ignored when no operation is selected.
// - One-step and two-step frames echo their tag beside the timestamp.
// - Timestamp is the timer value at start-of-packet, same layout as timer.
// - Checksum flag matters for one-step only; set means recompute UDP checksum.
// - Checksum offset counts bytes from destination address byte zero.
// - One-step timestamp goes at the timestamp offset; ignored otherwise.
// - In transparent clock mode the offset locates the correction field.
// - Normal clock 48s+32ns; transparent: sign, nanoseconds, fraction fields.
// - Timestamp-valid is raised while timestamp and tag are presented.
module tpr_tx_stamp
(
	input  wire                   i_clk_sys,        // Transmit clock, 100 MHz.
	input  wire                   i_resetn,         // Synchronous transmit path reset.
	input  wire                   i_tc_mode,        // High for transparent clock mode.
	input  wire [`TPR_TS_W-1:0]   i_timer,          // Transmit system timer.
	input  wire                   i_valid,          // Frame beat valid.
	input  wire                   i_sop,            // First beat of a frame.
	input  wire                   i_eop,            // Last beat of a frame.
	input  wire [`TPR_DATA_W-1:0] i_data,           // Beat data, byte 0 in low bits.
	input  wire [`TPR_OP_W-1:0]   i_frame_time_op_code, // Per-frame operation.
	input  wire [`TPR_TAG_W-1:0]  i_tag,            // Per-frame tag.
	input  wire                   i_upd_chksum,     // Recompute UDP checksum.
	input  wire [`TPR_OFS_W-1:0]  i_chksum_offset,  // Checksum byte position.
	input  wire [`TPR_OFS_W-1:0]  i_tstamp_offset,  // Timestamp byte position.
	output reg                    o_valid,          // Beat valid out.
	output reg                    o_sop,            // First beat out.
	output reg                    o_eop,            // Last beat out.
	output reg  [`TPR_DATA_W-1:0] o_data,           // Beat data out.
	output reg                    o_tstamp_valid,   // Returned timestamp valid.
	output reg  [`TPR_TS_W-1:0]   o_tstamp,         // Returned timestamp.
	output reg  [`TPR_TAG_W-1:0]  o_tstamp_tag      // Returned tag.
);

	////////////////////////////////////////////////////////////////////////////
	// Per-frame request held from start-of-packet.

	localparam ST_IDLE = 2'h0;
	localparam ST_PASS = 2'h1;
	localparam ST_ONE  = 2'h2;
	localparam ST_TWO  = 2'h3;

	reg  [1:0]            state_reg;
	reg  [1:0]            state_next;
	reg  [`TPR_TS_W-1:0]  ts_reg;
	reg  [`TPR_OFS_W-1:0] pos_reg;
	reg  [`TPR_OFS_W-1:0] ts_ofs_reg;
	reg  [`TPR_OFS_W-1:0] cs_ofs_reg;
	reg                   cs_en_reg;
	reg                   tc_reg;
	reg  [15:0]           csum_reg;

	wire                  sop_beat = i_valid & i_sop;
	wire [`TPR_OP_W-1:0]  op       = i_frame_time_op_code;

	// Request fields as seen on this beat: live at start-of-packet, held after.
	wire [1:0]            cur_state  = sop_beat ? state_next : state_reg;
	wire [`TPR_OFS_W-1:0] cur_pos    = sop_beat ? `TPR_ZERO_OFS : pos_reg;
	wire [`TPR_OFS_W-1:0] cur_ts_ofs = sop_beat ? i_tstamp_offset : ts_ofs_reg;
	wire [`TPR_OFS_W-1:0] cur_cs_ofs = sop_beat ? i_chksum_offset : cs_ofs_reg;
	wire                  cur_cs_en  = sop_beat ? i_upd_chksum : cs_en_reg;
	wire                  cur_tc     = sop_beat ? i_tc_mode : tc_reg;
	wire [`TPR_TS_W-1:0]  cur_ts     = sop_beat ? i_timer : ts_reg;

	// Decode the operation code; reserved code behaves as no operation.
	always @*
	begin
		case (op)
			`TPR_OP_NONE:     state_next = ST_PASS;
			`TPR_OP_ONE_STEP: state_next = ST_ONE;
			`TPR_OP_TWO_STEP: state_next = ST_TWO;
			default:          state_next = ST_PASS;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Field to insert and its length.

	// Transparent clock writes the 64-bit correction form at the offset.
	wire [`TPR_TS_W-1:0] tc_field = {16'h0, cur_ts[`TPR_TC_W-1:0]};
	wire [`TPR_TS_W-1:0] ins_field = cur_tc ? tc_field : cur_ts;
	wire [3:0]           ins_len   = cur_tc ? 4'd`TPR_TC_BYTES : 4'd`TPR_NC_BYTES;

	wire [`TPR_DATA_W-1:0] patched;
	wire [`TPR_DATA_W-1:0] cs_patched;
	wire [15:0]            csum_sum;
	wire [15:0]            csum_live;

	// Lays the timestamp into the beat at the client's offset.
	tpr_byte_patch u_ts_patch
	(
		.i_beat      (i_data),
		.i_beat_pos  (cur_pos),
		.i_field_pos (cur_ts_ofs),
		.i_field_len (ins_len),
		.i_field     (ins_field),
		.o_beat      (patched)
	);

	// Accumulates how much the insertion moved the ones-complement sum.
	tpr_csum_fix u_csum
	(
		.i_sum (sop_beat ? `TPR_ZERO_CSUM : csum_reg),
		.i_old (i_data),
		.i_new (patched),
		.o_sum (csum_sum)
	);

	// Checksum field overwritten with the accumulated sum alone. The checksum field
	// must lie after the timestamp so the full delta is known when it passes.
	assign csum_live = csum_sum;

	tpr_byte_patch u_cs_patch
	(
		.i_beat      (patched),
		.i_beat_pos  (cur_pos),
		.i_field_pos (cur_cs_ofs),
		.i_field_len (4'h2),
		.i_field     ({64'h0, csum_live}),
		.o_beat      (cs_patched)
	);

	////////////////////////////////////////////////////////////////////////////
	// Frame path: one register stage in all modes.

	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			state_reg  <= ST_IDLE;
			ts_reg     <= `TPR_ZERO_TS;
			pos_reg    <= `TPR_ZERO_OFS;
			ts_ofs_reg <= `TPR_ZERO_OFS;
			cs_ofs_reg <= `TPR_ZERO_OFS;
			cs_en_reg  <= 1'b0;
			tc_reg     <= 1'b0;
			csum_reg   <= `TPR_ZERO_CSUM;
			o_valid    <= 1'b0;
			o_sop      <= 1'b0;
			o_eop      <= 1'b0;
			o_data     <= `TPR_ZERO_DATA;
		end
		else
		begin
			o_valid <= i_valid;
			o_sop   <= sop_beat;
			o_eop   <= i_valid & i_eop;
			if (i_valid)
			begin
				if (cur_state == ST_ONE)
					o_data <= (cur_cs_en & ~cur_tc) | (cur_cs_en & cur_tc)
						? cs_patched : patched;
				else
					o_data <= i_data;
				pos_reg  <= cur_pos + 16'd`TPR_BYTES;
				csum_reg <= csum_sum;
			end
			if (sop_beat)
			begin
				// Request sampled once per frame at start-of-packet.
				state_reg  <= state_next;
				ts_reg     <= i_timer;
				ts_ofs_reg <= i_tstamp_offset;
				cs_ofs_reg <= i_chksum_offset;
				cs_en_reg  <= i_upd_chksum;
				tc_reg     <= i_tc_mode;
			end
			if (i_valid & i_eop)
				state_reg <= ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timestamp return: one pulse per stamped frame at start-of-packet.

	// Timer is sampled on the start-of-packet beat, which is the capture plane.
	always @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			o_tstamp_valid <= 1'b0;
			o_tstamp       <= `TPR_ZERO_TS;
			o_tstamp_tag   <= `TPR_ZERO_TAG;
		end
		else
		begin
			o_tstamp_valid <= 1'b0;
			if (sop_beat & ((op == `TPR_OP_ONE_STEP) | (op == `TPR_OP_TWO_STEP)))
			begin
				o_tstamp_valid <= 1'b1;
				o_tstamp       <= i_timer;
				o_tstamp_tag   <= i_tag;
			end
		end
	end

endmodule // tpr_tx_stamp

// ### design/tpr_defs.vh
`ifndef TPR_DEFS_VH
`define TPR_DEFS_VH

// Operation codes presented with each frame.
`define TPR_OP_NONE      2'h0
`define TPR_OP_ONE_STEP  2'h1
`define TPR_OP_TWO_STEP  2'h2
`define TPR_OP_RESERVED  2'h3

// Widths of the request and timestamp fields.
`define TPR_OP_W         2
`define TPR_TAG_W        16
`define TPR_OFS_W        16
`define TPR_TS_W         80
`define TPR_DATA_W       64
`define TPR_BYTES        8
`define TPR_BIDX_W       3

// Timestamp layouts: normal clock seconds and nanoseconds, transparent clock fields.
`define TPR_TS_SEC_HI    79
`define TPR_TS_SEC_LO    32
`define TPR_TS_NS_HI     31
`define TPR_TS_NS_LO     0
`define TPR_TC_SIGN      63
`define TPR_TC_NS_HI     62
`define TPR_TC_NS_LO     16
`define TPR_TC_FRAC_HI   15
`define TPR_TC_FRAC_LO   0
`define TPR_TC_W         64
`define TPR_TC_BYTES     8
`define TPR_NC_BYTES     10

// Reset values.
`define TPR_ZERO_TS      80'h0
`define TPR_ZERO_TAG     16'h0
`define TPR_ZERO_OFS     16'h0
`define TPR_ZERO_DATA    64'h0
`define TPR_ZERO_CSUM    16'h0

`endif

// ### design/tpr_byte_patch.v
`timescale 1ns/1ps
`include "tpr_defs.vh"

// Overwrites the bytes of one data beat that fall inside a field window.
// The field is held most significant byte first, as it travels on the wire.
module tpr_byte_patch
(
	input  wire [`TPR_DATA_W-1:0] i_beat,      // Beat as it arrives.
	input  wire [`TPR_OFS_W-1:0]  i_beat_pos,  // Frame byte index of beat byte 0.
	input  wire [`TPR_OFS_W-1:0]  i_field_pos, // Frame byte index of first field byte.
	input  wire [3:0]             i_field_len, // Field length in bytes.
	input  wire [`TPR_TS_W-1:0]   i_field,     // Field, right aligned.
	output reg  [`TPR_DATA_W-1:0] o_beat       // Beat with the field laid in.
);

	integer k;
	reg [`TPR_OFS_W-1:0] rel;

	// Byte k of the beat takes field byte rel when rel lies in the window.
	always @*
	begin
		o_beat = i_beat;
		rel = `TPR_ZERO_OFS;
		for (k = 0; k < `TPR_BYTES; k = k + 1)
		begin
			rel = i_beat_pos + k[`TPR_OFS_W-1:0] - i_field_pos;
			if (rel < {12'h0, i_field_len})
				o_beat[k*8 +: 8] = i_field[(i_field_len - 1 - rel[3:0])*8 +: 8];
		end
	end

endmodule // tpr_byte_patch

// ### design/tpr_csum_fix.v
`timescale 1ns/1ps
`include "tpr_defs.vh"

// Incremental ones-complement update of a checksum after words were replaced.
// Adding the new words and the complement of the old ones keeps the sum valid
// without a second pass over the frame, which a cut-through path cannot afford.
module tpr_csum_fix
(
	input  wire [15:0]             i_sum,   // Running partial sum.
	input  wire [`TPR_DATA_W-1:0]  i_old,   // Beat before patching.
	input  wire [`TPR_DATA_W-1:0]  i_new,   // Beat after patching.
	output wire [15:0]             o_sum    // Updated partial sum.
);

	// Ones-complement addition with end-around carry.
	function [15:0] oc_add;
		input [15:0] a;
		input [15:0] b;
		reg   [16:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			oc_add = s[15:0] + {15'h0, s[16]};
		end
	endfunction

	wire [15:0] d0 = oc_add(i_new[15:0],  ~i_old[15:0]);
	wire [15:0] d1 = oc_add(i_new[31:16], ~i_old[31:16]);
	wire [15:0] d2 = oc_add(i_new[47:32], ~i_old[47:32]);
	wire [15:0] d3 = oc_add(i_new[63:48], ~i_old[63:48]);

	// Fold the four word differences into the running sum.
	assign o_sum = oc_add(oc_add(i_sum, oc_add(d0, d1)), oc_add(d2, d3));

endmodule // tpr_csum_fix

// ### bench/tpr_tx_stamp_properties.sv
`timescale 1ns/1ps
`include "tpr_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the stamping block.
module tpr_chk
(
	input wire                   i_clk_sys,            // Clock.
	input wire                   i_resetn,             // Reset.
	input wire                   i_tc_mode,            // Clock mode.
	input wire [`TPR_TS_W-1:0]   i_timer,              // Timer.
	input wire                   i_valid,              // Beat valid.
	input wire                   i_sop,                // First beat.
	input wire [`TPR_DATA_W-1:0] i_data,               // Beat in.
	input wire [`TPR_OP_W-1:0]   i_frame_time_op_code, // Operation.
	input wire [`TPR_TAG_W-1:0]  i_tag,                // Tag in.
	input wire [`TPR_OFS_W-1:0]  i_tstamp_offset,      // Stamp offset.
	input wire [`TPR_DATA_W-1:0] o_data,               // Beat out.
	input wire                   o_tstamp_valid,       // Stamp pulse.
	input wire [`TPR_TS_W-1:0]   o_tstamp,             // Stamp.
	input wire [`TPR_TAG_W-1:0]  o_tstamp_tag          // Tag out.
);
	// The odd parity of the code picks 01 and 10, so reserved 11 counts as none.
	wire req   = i_valid && i_sop;
	wire stamp = req && ^i_frame_time_op_code;
	wire one   = req && i_frame_time_op_code == `TPR_OP_ONE_STEP && i_tstamp_offset == 16'h0;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	none_quiet_a:
		assert property (req && i_frame_time_op_code == 2'h0 |=> !o_tstamp_valid)
		else $error("stamp pulse on a no-op frame");
	stamp_pulse_a:
		assert property (stamp |=> o_tstamp_valid) else $error("stamp pulse missing");
	stamp_time_a:
		assert property (stamp |=> o_tstamp == $past(i_timer)) else $error("stamp value wrong");
	tag_echo_a:
		assert property (stamp |=> o_tstamp_tag == $past(i_tag)) else $error("tag echo wrong");
	tag_hold_a:
		assert property (req && !(^i_frame_time_op_code) |=> $stable(o_tstamp_tag))
		else $error("tag moved on a no-op frame");
	data_kept_a:
		assert property (i_valid && i_frame_time_op_code != 2'h1 |=> o_data == $past(i_data))
		else $error("frame altered");
	patch_norm_a:
		assert property (one && !i_tc_mode |=> o_data[7:0] == $past(i_timer[79:72]))
		else $error("stamp byte zero wrong");
	patch_tc_a:
		assert property (one && i_tc_mode |=> o_data[7:0] == $past(i_timer[63:56]))
		else $error("correction byte zero wrong");
endmodule // tpr_chk

bind tpr_tx_stamp tpr_chk chk_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
	.i_tc_mode(i_tc_mode), .i_timer(i_timer), .i_valid(i_valid), .i_sop(i_sop),
	.i_data(i_data), .i_frame_time_op_code(i_frame_time_op_code), .i_tag(i_tag),
	.i_tstamp_offset(i_tstamp_offset), .o_data(o_data), .o_tstamp_valid(o_tstamp_valid),
	.o_tstamp(o_tstamp), .o_tstamp_tag(o_tstamp_tag));

// ### bench/tpr_client.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Client transmit logic: one beat a cycle, fields change after falling edges.
module tpr_client
(
	input  wire        i_clk_sys, // Clock.
	output reg         o_tc,      // Clock mode.
	output reg         o_valid,   // Beat valid.
	output reg         o_sop,     // First beat.
	output reg         o_eop,     // Last beat.
	output reg  [63:0] o_data,    // Beat data.
	output reg  [1:0]  o_op,      // Operation.
	output reg  [15:0] o_tag,     // Tag.
	output reg         o_upd,     // Checksum flag.
	output reg  [15:0] o_cofs,    // Checksum offset.
	output reg  [15:0] o_tofs     // Stamp offset.
);
	integer k;
	initial
	begin
		{o_tc, o_valid, o_sop, o_eop, o_data, o_op, o_tag, o_upd, o_cofs, o_tofs} = 0;
	end
	// One frame; the request stays put from first to last beat.
	task send(input [1:0] op, input tc, input upd, input [15:0] tofs, input integer n);
	begin
		o_op <= op;
		o_tc <= tc;
		o_upd <= upd;
		o_tag <= $urandom;
		o_tofs <= tofs & 16'hFFFE;
		o_cofs <= (tofs + 16'h000A) & 16'hFFFE;
		for (k = 0; k < n; k = k + 1)
		begin
			o_valid <= 1'b1;
			o_sop <= (k == 0);
			o_eop <= (k == n - 1);
			o_data <= {$urandom, $urandom};
			@(negedge i_clk_sys);
		end
	end
	endtask
	// Idle beat with junk data, so a stale value never passes for a frame.
	task idle;
	begin
		o_valid <= 1'b0;
		o_sop <= 1'b0;
		o_eop <= 1'b0;
		o_data <= {$urandom, $urandom};
		@(negedge i_clk_sys);
	end
	endtask
endmodule // tpr_client

// ### bench/tb_tpr_tx_stamp.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Stamping block against a behavioural model of its frame path.
module tb_tpr_tx_stamp;
	reg         clk_sys, resetn, chk_on, m_tc, e_valid, e_tsv, e_sop, e_eop;
	wire        o_sp, o_ep;
	reg  [79:0] timer, m_t, e_ts;
	reg  [63:0] e_data;
	reg  [15:0] e_tag;
	reg  [1:0]  m_op;
	wire        tc, valid, sop, eop, upd, o_valid, o_tsv;
	wire [63:0] data, o_data;
	wire [1:0]  op;
	wire [15:0] tag, cofs, tofs, o_tag;
	wire [79:0] o_ts;
	integer     failures, tests_run, pos, m_ofs, k, n, p, i, o;
	tpr_client cli_u (.i_clk_sys(clk_sys), .o_tc(tc), .o_valid(valid), .o_sop(sop),
		.o_eop(eop), .o_data(data), .o_op(op), .o_tag(tag), .o_upd(upd), .o_cofs(cofs),
		.o_tofs(tofs));
	tpr_tx_stamp dut_u (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_tc_mode(tc),
		.i_timer(timer), .i_valid(valid), .i_sop(sop), .i_eop(eop), .i_data(data),
		.i_frame_time_op_code(op), .i_tag(tag), .i_upd_chksum(upd), .i_chksum_offset(cofs),
		.i_tstamp_offset(tofs), .o_valid(o_valid), .o_sop(o_sp), .o_eop(o_ep), .o_data(o_data),
		.o_tstamp_valid(o_tsv), .o_tstamp(o_ts), .o_tstamp_tag(o_tag));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Timer moves at random, so a stamp taken one cycle off cannot match.
	always @(negedge clk_sys) timer <= {timer[47:0], $urandom};
	task check(input [127:0] name, input [79:0] exp, input [79:0] got);
	begin
		tests_run = tests_run + 1;
		if (exp !== got)
		begin
			failures = failures + 1;
			$display("FAIL %0s expected %h seen %h", name, exp, got);
		end
	end
	endtask
	task results;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// Model: one-step lays the stamp in most significant byte first.
	always @(posedge clk_sys)
	begin
		e_valid <= resetn && valid;
		e_sop <= resetn && valid && sop;
		e_eop <= resetn && valid && eop;
		e_tsv <= resetn && valid && sop && (op == 2'h1 || op == 2'h2);
		if (valid && sop)
		begin
			{m_op, m_tc, m_t, e_ts, e_tag} = {op, tc, timer, timer, tag};
			m_ofs = tofs;
			pos = 0;
		end
		n = m_tc ? 8 : 10;
		for (k = 0; k < 8; k = k + 1)
		begin
			p = pos + k - m_ofs;
			e_data[8*k+:8] <= (m_op == 2'h1 && p >= 0 && p < n) ? m_t[8*(n-1-p)+:8] : data[8*k+:8];
		end
		pos = pos + (valid ? 8 : 0);
	end
	// Results settle by the falling edge.
	always @(negedge clk_sys)
	begin
		if (chk_on)
		begin
			check("o_valid", e_valid, o_valid);
			check("o_tstamp_valid", e_tsv, o_tsv);
			check("o_sop", e_sop, o_sp);
			check("o_eop", e_eop, o_ep);
			if (e_valid) check("o_data", e_data, o_data);
			if (e_tsv) check("o_tstamp", e_ts, o_ts);
			if (e_tsv) check("o_tstamp_tag", e_tag, o_tag);
		end
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		failures = failures + 1;
		results;
	end
	initial
	begin
		{failures, tests_run, chk_on, resetn, timer} = 0;
		i = $urandom(32'hF3BB);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn = 1'b1;
		chk_on = 1'b1;
		cli_u.idle;
		for (i = 0; i < 90; i = i + 1)
		begin
			o = i % 3;
			cli_u.send(o[1:0], i[2], (o != 1) & i[1], (i < 6) ? 16'h0 : 16'($urandom % 16 * 2),
				1 + $urandom % 4);
			if (i[3]) cli_u.idle;
		end
		cli_u.idle;
		resetn = 1'b0;
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		cli_u.idle;
		cli_u.send(2'h2, 1'b0, 1'b1, 16'h0, 1);
		cli_u.send(2'h1, 1'b1, 1'b0, 16'h0006, 2);
		cli_u.idle;
		cli_u.idle;
		results;
	end
endmodule // tb_tpr_tx_stamp
